//--- core/cpm_defines.svh
// Register map, field layout, reset values and function codes of the codec pin mux
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
// ==========================================================
// Register offsets
`define CPM_MP_OFS        8'h33
`define CPM_RSVD_OFS      8'h34
`define CPM_DOUT_OFS      8'h35
`define CPM_DIN_OFS       8'h36
// ==========================================================
// Reset values and writable-bit masks
`define CPM_MP_RST        8'h00
`define CPM_DOUT_RST      8'h12
`define CPM_DIN_RST       8'h02
`define CPM_MP_WMASK      8'hFD
`define CPM_DOUT_WMASK    8'hFF
`define CPM_DIN_WMASK     8'hFE
`define CPM_RSVD_RDATA    8'h00
// ==========================================================
// Field positions
`define CPM_MP_FN_MSB     5
`define CPM_MP_FN_LSB     2
`define CPM_MP_IN_BIT     1
`define CPM_MP_GPO_BIT    0
`define CPM_DOUT_KEEP_BIT 4
`define CPM_DOUT_FN_MSB   3
`define CPM_DOUT_FN_LSB   1
`define CPM_DOUT_GPO_BIT  0
`define CPM_DIN_FN_MSB    2
`define CPM_DIN_FN_LSB    1
`define CPM_DIN_IN_BIT    0
// ==========================================================
// Multipurpose pin function codes
`define CPM_MP_OFF        4'h0
`define CPM_MP_INPUT      4'h1
`define CPM_MP_GPI        4'h2
`define CPM_MP_GPO        4'h3
`define CPM_MP_CLKO       4'h4
`define CPM_MP_INTERRUPT_LINE_ONE       4'h5
`define CPM_MP_INTERRUPT_LINE_TWO       4'h6
`define CPM_MP_RWCLK      4'h7
`define CPM_MP_SBCLK      4'h8
`define CPM_MP_SWCLK      4'h9
`define CPM_MP_MODCLK     4'hA
`define CPM_MP_SDOUT      4'hB
// ==========================================================
// Data output pin function codes
`define CPM_DO_OFF        3'h0
`define CPM_DO_PRIM       3'h1
`define CPM_DO_GPO        3'h2
`define CPM_DO_CLKO       3'h3
`define CPM_DO_INTERRUPT_LINE_ONE       3'h4
`define CPM_DO_INTERRUPT_LINE_TWO       3'h5
`define CPM_DO_SBCLK      3'h6
`define CPM_DO_SWCLK      3'h7
// ==========================================================
// Data input pin function codes
`define CPM_DI_OFF        2'h0
`define CPM_DI_EN         2'h1
`define CPM_DI_GPI        2'h2
`endif

//--- core/cpm_pkg.sv
// Types shared by the codec pin mux
package cpm_pkg;
    // Internal signal sources that may be routed to the output pins
    typedef struct packed {
        logic clock_output;
        logic interrupt_line_one;
        logic interrupt_line_two;
        logic record_wclk;
        logic sec_bclk;
        logic sec_wclk;
        logic microphone_modulator_clock;
        logic sec_dout;
        logic prim_dout;
    } cpm_src_t;
    // Pin levels handed to the internal consumers
    typedef struct packed {
        logic mp_level;
        logic din_level;
    } cpm_fanin_t;
endpackage

//--- core/cpm_pin_mux.sv
// Register-controlled function mux for the multipurpose, data output and data input pins
`timescale 1ns/10ps
`include "cpm_defines.svh"

module cpm_pin_mux (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // Register port
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rd_valid,
    // Internal sources and consumers
    input  wire cpm_pkg::cpm_src_t src,
    output cpm_pkg::cpm_fanin_t    fanin,
    // Multipurpose pin
    input  wire logic              mp_pin_in,
    output logic                   mp_pin_out,
    output logic                   mp_pin_oe,
    output logic                   mp_in_buf_en,
    // Data output pin
    output logic                   dout_pin_out,
    output logic                   dout_pin_oe,
    output logic                   dout_keeper_en,
    // Data input pin
    input  wire logic              din_pin_in,
    output logic                   din_in_buf_en
);

    // ==========================================================
    // Control registers
    logic [7:0] mp_ctl_q;
    logic [7:0] dout_ctl_q;
    logic [7:0] din_ctl_q;
    logic       mp_in_q;
    logic       din_in_q;

    logic [3:0] mp_fn;
    logic [2:0] dout_fn;
    logic [1:0] din_fn;

    assign mp_fn   = mp_ctl_q[`CPM_MP_FN_MSB:`CPM_MP_FN_LSB];
    assign dout_fn = dout_ctl_q[`CPM_DOUT_FN_MSB:`CPM_DOUT_FN_LSB];
    assign din_fn  = din_ctl_q[`CPM_DIN_FN_MSB:`CPM_DIN_FN_LSB];

    // Read-only bits are masked so a write never lands in them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mp_ctl_q <= `CPM_MP_RST;
        end else if (reg_wr_en && reg_addr == `CPM_MP_OFS) begin
            mp_ctl_q <= reg_wdata & `CPM_MP_WMASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dout_ctl_q <= `CPM_DOUT_RST;
        end else if (reg_wr_en && reg_addr == `CPM_DOUT_OFS) begin
            dout_ctl_q <= reg_wdata & `CPM_DOUT_WMASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            din_ctl_q <= `CPM_DIN_RST;
        end else if (reg_wr_en && reg_addr == `CPM_DIN_OFS) begin
            din_ctl_q <= reg_wdata & `CPM_DIN_WMASK;
        end
    end

    // ==========================================================
    // Multipurpose pin function decode
    logic mp_oe_d;
    logic mp_out_d;
    logic mp_buf_d;

    // Reserved codes fall to the powered-down state, the safest choice for a pad
    always_comb begin
        mp_oe_d  = 1'b1;
        mp_out_d = 1'b0;
        mp_buf_d = 1'b1;
        case (mp_fn)
            `CPM_MP_OFF: begin
                mp_oe_d  = 1'b0;
                mp_buf_d = 1'b0;
            end
            `CPM_MP_INPUT: mp_oe_d = 1'b0;
            `CPM_MP_GPI:   mp_oe_d = 1'b0;
            `CPM_MP_GPO:   mp_out_d = mp_ctl_q[`CPM_MP_GPO_BIT];
            `CPM_MP_CLKO:  mp_out_d = src.clock_output;
            `CPM_MP_INTERRUPT_LINE_ONE:  mp_out_d = src.interrupt_line_one;
            `CPM_MP_INTERRUPT_LINE_TWO:  mp_out_d = src.interrupt_line_two;
            `CPM_MP_RWCLK: mp_out_d = src.record_wclk;
            `CPM_MP_SBCLK: mp_out_d = src.sec_bclk;
            `CPM_MP_SWCLK: mp_out_d = src.sec_wclk;
            `CPM_MP_MODCLK: mp_out_d = src.microphone_modulator_clock;
            `CPM_MP_SDOUT: mp_out_d = src.sec_dout;
            default: begin
                mp_oe_d  = 1'b0;
                mp_buf_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mp_pin_oe    <= 1'b0;
            mp_pin_out   <= 1'b0;
            mp_in_buf_en <= 1'b0;
        end else begin
            mp_pin_oe    <= mp_oe_d;
            mp_pin_out   <= mp_out_d;
            mp_in_buf_en <= mp_buf_d;
        end
    end

    // ==========================================================
    // Data output pin function decode
    logic dout_oe_d;
    logic dout_out_d;

    always_comb begin
        dout_oe_d  = 1'b1;
        dout_out_d = 1'b0;
        case (dout_fn)
            `CPM_DO_OFF:   dout_oe_d  = 1'b0;
            `CPM_DO_PRIM:  dout_out_d = src.prim_dout;
            `CPM_DO_GPO:   dout_out_d = dout_ctl_q[`CPM_DOUT_GPO_BIT];
            `CPM_DO_CLKO:  dout_out_d = src.clock_output;
            `CPM_DO_INTERRUPT_LINE_ONE:  dout_out_d = src.interrupt_line_one;
            `CPM_DO_INTERRUPT_LINE_TWO:  dout_out_d = src.interrupt_line_two;
            `CPM_DO_SBCLK: dout_out_d = src.sec_bclk;
            default:       dout_out_d = src.sec_wclk;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dout_pin_oe    <= 1'b0;
            dout_pin_out   <= 1'b0;
            dout_keeper_en <= 1'b0;
        end else begin
            dout_pin_oe    <= dout_oe_d;
            dout_pin_out   <= dout_out_d;
            dout_keeper_en <= ~dout_ctl_q[`CPM_DOUT_KEEP_BIT];
        end
    end

    // ==========================================================
    // Input buffers and internal fan-in
    logic din_buf_d;

    // Reserved code 11 is treated as powered down
    assign din_buf_d = (din_fn == `CPM_DI_EN) || (din_fn == `CPM_DI_GPI);

    // A powered-down buffer reads as zero rather than a floating level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mp_in_q  <= 1'b0;
            din_in_q <= 1'b0;
        end else begin
            mp_in_q  <= mp_buf_d & mp_pin_in;
            din_in_q <= din_buf_d & din_pin_in;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            din_in_buf_en <= 1'b0;
            fanin         <= '0;
        end else begin
            din_in_buf_en   <= din_buf_d;
            fanin.mp_level  <= (mp_fn == `CPM_MP_INPUT) & mp_in_q;
            fanin.din_level <= (din_fn == `CPM_DI_EN) & din_in_q;
        end
    end

    // ==========================================================
    // Register readback, one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (!reg_rd_en) begin
                reg_rdata <= reg_rdata;
            end else if (reg_addr == `CPM_MP_OFS) begin
                reg_rdata <= {mp_ctl_q[7:2], mp_in_q, mp_ctl_q[0]};
            end else if (reg_addr == `CPM_DOUT_OFS) begin
                reg_rdata <= dout_ctl_q;
            end else if (reg_addr == `CPM_DIN_OFS) begin
                reg_rdata <= {din_ctl_q[7:1], din_in_q};
            end else begin
                reg_rdata <= `CPM_RSVD_RDATA;
            end
        end
    end

    // ==========================================================
    // Checks
    mp_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_OFF) |=> (!mp_pin_oe && !mp_in_buf_en))
        else $error("multipurpose pin not powered down in off code");

    mp_input_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_INPUT) |=> (!mp_pin_oe && mp_in_buf_en
            && fanin.mp_level == $past(mp_in_q)))
        else $error("multipurpose input level not handed on");

    mp_gpi_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_GPI) |=> (!mp_pin_oe && mp_in_buf_en && !fanin.mp_level))
        else $error("multipurpose general input mode wrong");

    mp_gpo_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_GPO) |=> (mp_pin_oe && mp_pin_out == $past(mp_ctl_q[0])))
        else $error("multipurpose general output level wrong");

    mp_gpo_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_wr_en && reg_addr == `CPM_MP_OFS && reg_wdata[5:0] == 6'h0D)
            |=> ##1 (mp_pin_oe && mp_pin_out))
        else $error("written general output level not driven");

    mp_int_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_INTERRUPT_LINE_ONE) |=> (mp_pin_out == $past(src.interrupt_line_one)))
        else $error("interrupt line one not on multipurpose pin");

    mp_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_SBCLK) |=> (mp_pin_oe && mp_pin_out == $past(src.sec_bclk)))
        else $error("secondary bit clock not on multipurpose pin");

    mp_sdout_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_SDOUT) |=> (mp_pin_out == $past(src.sec_dout)))
        else $error("secondary data not on multipurpose pin");

    mp_modclk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mp_fn == `CPM_MP_MODCLK)
            |=> (mp_pin_out == $past(src.microphone_modulator_clock)))
        else $error("modulator clock not on multipurpose pin");

    mp_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (reg_rd_en && reg_addr == `CPM_MP_OFS && mp_buf_d)
            |=> (reg_rd_valid && reg_rdata[1] == $past(mp_in_q)))
        else $error("multipurpose input readback wrong");

    keeper_ctl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 (dout_keeper_en == !$past(dout_ctl_q[4])))
        else $error("keeper enable does not follow control bit");

    dout_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (dout_fn == `CPM_DO_PRIM) |=> (dout_pin_oe && dout_pin_out == $past(src.prim_dout)))
        else $error("primary data not on data output pin");

    dout_int_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (dout_fn == `CPM_DO_INTERRUPT_LINE_TWO) |=> (dout_pin_out == $past(src.interrupt_line_two)))
        else $error("interrupt line two not on data output pin");

    dout_clk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (dout_fn == `CPM_DO_SWCLK) |=> (dout_pin_out == $past(src.sec_wclk)))
        else $error("secondary word clock not on data output pin");

    dout_gpo_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (dout_fn == `CPM_DO_GPO) |=> (dout_pin_oe && dout_pin_out == $past(dout_ctl_q[0])))
        else $error("data output general level wrong");

    din_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (din_fn == `CPM_DI_OFF) |=> (!din_in_buf_en && !fanin.din_level))
        else $error("data input buffer not powered down");

    din_gpi_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (din_fn == `CPM_DI_GPI && reg_rd_en && reg_addr == `CPM_DIN_OFS)
            |=> (reg_rdata[0] == $past(din_in_q) && !fanin.din_level))
        else $error("data input readback wrong");

endmodule

//--- verif/cpm_pad_model.sv
// Behavioural model of the pads and the peripherals around the pin mux
`timescale 1ns/10ps

module cpm_pad_model (
    // Device side of the pads
    input  wire logic mp_pin_out,
    input  wire logic mp_pin_oe,
    // Levels offered by the external peripherals
    input  wire logic ext_mp,
    input  wire logic ext_din,
    // Pad levels seen by the device
    output logic      mp_pin_in,
    output logic      din_pin_in
);
    // The pad shows the device's own level while it drives, else the peripheral's
    assign mp_pin_in  = mp_pin_oe ? mp_pin_out : ext_mp;
    assign din_pin_in = ext_din;
endmodule

//--- verif/cpm_pin_mux_test.sv
// Self-checking testbench of the codec pin mux
`timescale 1ns/10ps
`include "cpm_defines.svh"

module cpm_pin_mux_test;
    // ==========================================================
    // Signals
    logic                clk_sys;
    logic                rst_b;
    logic                reg_wr_en;
    logic                reg_rd_en;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic                reg_rd_valid;
    cpm_pkg::cpm_src_t   src;
    cpm_pkg::cpm_fanin_t fanin;
    logic                mp_pin_in;
    logic                mp_pin_out;
    logic                mp_pin_oe;
    logic                mp_in_buf_en;
    logic                dout_pin_out;
    logic                dout_pin_oe;
    logic                dout_keeper_en;
    logic                din_pin_in;
    logic                din_in_buf_en;
    logic                ext_mp;
    logic                ext_din;
    logic [31:0]         rng_q;
    logic [7:0]          exp_q[$];
    int                  err_total;
    int                  n_compared;

    cpm_pin_mux i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .src(src), .fanin(fanin), .mp_pin_in(mp_pin_in),
        .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe), .mp_in_buf_en(mp_in_buf_en),
        .dout_pin_out(dout_pin_out), .dout_pin_oe(dout_pin_oe),
        .dout_keeper_en(dout_keeper_en), .din_pin_in(din_pin_in),
        .din_in_buf_en(din_in_buf_en)
    );

    cpm_pad_model i_pads (
        .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe), .ext_mp(ext_mp),
        .ext_din(ext_din), .mp_pin_in(mp_pin_in), .din_pin_in(din_pin_in)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: read expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_pin(input logic [2:0] exp, input logic [2:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: pins expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk_sys) #1;
        reg_wr_en = 1'b0;
    endtask

    // Notes the expected value, then waits a bounded time for the monitor to take it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys) #1;
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(posedge clk_sys) #1;
        reg_rd_en = 1'b0;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk_sys);
        #1;
        if (exp_q.size() != 0) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 rst_b = 1'b1;
    endtask

    // ==========================================================
    // Clock and read monitor
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        #2;
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("Error at %0t: unexpected read %h", $time, reg_rdata);
            end else begin
                chk_rd(exp_q.pop_front(), reg_rdata);
            end
        end
    end

    // ==========================================================
    // Stimulus
    initial begin
        logic        g;
        logic        e_oe;
        logic        e_out;
        logic        e_buf;
        logic        pad;
        logic [15:0] sel;
        logic [7:0]  w;
        logic [1:0]  dc;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        src = '0;
        ext_mp = 1'b0;
        ext_din = 1'b0;
        rng_q = 32'h7;
        err_total = 0;
        n_compared = 0;
        do_reset();
        cyc(2);
        chk_pin(3'b101, {dout_pin_oe, dout_keeper_en, din_in_buf_en});
        chk_pin(3'b000, {mp_pin_oe, mp_in_buf_en, fanin.mp_level});
        rd(`CPM_MP_OFS, 8'h00);
        rd(`CPM_DOUT_OFS, 8'h12);
        rd(`CPM_DIN_OFS, 8'h02);
        rd(8'h40, 8'h00);
        // Every legal multipurpose code with random sources and pad level
        for (int c = 0; c < 12; c++) begin
            rng_q = xs(rng_q);
            src = rng_q[8:0];
            ext_mp = rng_q[9];
            g = rng_q[10];
            wr(`CPM_MP_OFS, {2'b00, c[3:0], rng_q[11], g});
            cyc(5);
            sel = {4'h0, src.sec_dout, src.microphone_modulator_clock, src.sec_wclk,
                   src.sec_bclk, src.record_wclk, src.interrupt_line_two,
                   src.interrupt_line_one, src.clock_output, g, 3'b000};
            e_buf = (c >= 1 && c <= 11);
            e_oe = (c >= 3 && c <= 11);
            e_out = sel[c[3:0]] & e_oe;
            pad = e_oe ? e_out : ext_mp;
            chk_pin({e_oe, e_buf, e_out}, {mp_pin_oe, mp_in_buf_en, mp_pin_out});
            chk_pin({2'b00, (c == 1) & pad}, {2'b00, fanin.mp_level});
            rd(`CPM_MP_OFS, {2'b00, c[3:0], e_buf & pad, g});
        end
        // Every data output code with the keeper bit at both values
        for (int c = 0; c < 16; c++) begin
            rng_q = xs(rng_q);
            src = rng_q[8:0];
            g = rng_q[10];
            w = {3'b000, c[3:0], g};
            wr(`CPM_DOUT_OFS, w);
            cyc(5);
            sel = {8'h00, src.sec_wclk, src.sec_bclk, src.interrupt_line_two,
                   src.interrupt_line_one, src.clock_output, g, src.prim_dout, 1'b0};
            e_oe = (c[2:0] != 3'b000);
            e_out = sel[c[2:0]];
            chk_pin({e_oe, ~c[3], e_out}, {dout_pin_oe, dout_keeper_en, dout_pin_out});
            rd(`CPM_DOUT_OFS, w);
        end
        // Legal data input codes twice each; the read-only level bit is written at random
        for (int c = 0; c < 6; c++) begin
            dc = 2'(c % 3);
            rng_q = xs(rng_q);
            ext_din = rng_q[12];
            wr(`CPM_DIN_OFS, {5'b00000, dc, rng_q[13]});
            cyc(5);
            e_buf = (dc == 2'b01 || dc == 2'b10);
            e_out = (dc == 2'b01) & ext_din;
            chk_pin({1'b0, e_buf, e_out}, {1'b0, din_in_buf_en, fanin.din_level});
            rd(`CPM_DIN_OFS, {5'b00000, dc, e_buf & ext_din});
        end
        // The reserved place is only ever read; an unmapped write must change nothing
        wr(8'h40, 8'hFF);
        rd(`CPM_RSVD_OFS, 8'h00);
        rd(8'h40, 8'h00);
        rd(`CPM_DIN_OFS, {5'b00000, dc, e_buf & ext_din});
        do_reset();
        cyc(2);
        rd(`CPM_DOUT_OFS, 8'h12);
        rd(`CPM_MP_OFS, 8'h00);
        summarize();
    end
endmodule
